/* design/dpc_defines.svh */
// Operation
// - Activate takes row; read/write column, A10 autoprecharge
// - Precharge A10 low one bank, high all
// - Mode load takes opcode from address
// - OTF chop: A12 high BL8, low BC4
// - Bank inputs select command target bank
// - Bank inputs pick mode register zero..three
// - Control and address registered on rising clock
// - Clock enable low: powerdown or self refresh
// - Self refresh exit asynchronous on clock enable; the code samples clock enable on the rising clock
// - Power states gate input buffers
// - Chip select high masks every command
// - Command from row, column, write strobes
// - Masked write beats are not stored
// - Termination strobe enabled disables data mask
// - Termination pin gates data termination
// - Termination disabled by mode ignores pin
// - Reset active low, asynchronous in effect; the code samples reset on the rising clock
// - Strobe driven with reads, received with writes; the code has no strobe input and takes write beats without it
// - Data bus four or eight bits
// - Upper balls unused in nibble configuration
// - Mode bit selects shared ball function
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
`define DPC_AP_BIT        10
`define DPC_BC_BIT        12
`define DPC_OTF_BIT       1
`define DPC_RTT_LSB       2
`define DPC_TDQS_BIT      11
`define DPC_MODE_RESET    16'h0000
`define DPC_READ_LAT      4'h5
`define DPC_WRITE_LAT     4'h5
`endif

/* design/dpc_pkg.sv */
`default_nettype none
package dpc_pkg;
    typedef enum logic [2:0] {
        DPC_NOP, DPC_MRS, DPC_REF, DPC_PRE, DPC_ACT, DPC_WR, DPC_RD, DPC_ZQ
    } dpc_cmd_e;
    typedef struct packed {
        logic        csN;
        logic        rasN;
        logic        casN;
        logic        weN;
        logic [2:0]  bank;
        logic [14:0] addr;
    } dpc_ca_s;
    typedef struct packed {
        logic [7:0] data;
        logic       mask;
    } dpc_beat_s;
endpackage
`default_nettype wire

/* design/dpc_skid.sv */
`default_nettype none
module dpc_skid #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             inValid,
    output var  logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output var  logic             outValid,
    input  wire logic             outReady,
    output var  logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] slot [2];
    logic             rdPtr;
    logic             wrPtr;
    logic [1:0]       count;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData  = slot[rdPtr];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdPtr <= 1'b0;
            wrPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wrPtr <= ~wrPtr;
            end
            if (pop) begin
                rdPtr <= ~rdPtr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            slot[wrPtr] <= inData;
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!reset_n)
        count != 2'h3) else $error("buffer count out of range");
endmodule
`default_nettype wire

/* design/dpc_pin_interface.sv */
`include "dpc_defines.svh"
`default_nettype none
module dpc_pin_interface #(
    parameter int  DQ_WIDTH = 8,
    parameter bit  BYTE_CFG = 1'b1
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset_n,
    // Command, address, control
    input  wire dpc_pkg::dpc_ca_s    ca,
    input  wire logic                clkEn,
    input  wire logic                odtPin,
    // Write data path
    input  wire dpc_pkg::dpc_beat_s  wrBeat,
    input  wire logic                wrBeatValid,
    // Read data path
    input  wire logic [7:0]          rdData,
    // Pins out
    output logic [7:0]               dqOut,
    output logic [7:0]               dqOe_n,
    output logic                     dqsOut,
    output logic                     dqsOe_n,
    output logic                     termStrobe,
    output logic                     termStrobeN,
    // Decoded state
    output logic [2:0]               cmdCode,
    output logic                     cmdValid,
    output logic [2:0]               cmdBank,
    output logic [14:0]              rowAddr,
    output logic [11:0]              colAddr,
    output logic                     autoPrecharge,
    output logic                     prechargeAll,
    output logic                     burstChop,
    output logic [7:0]               bankOpen,
    output logic                     powerDown,
    output logic                     selfRefresh,
    output logic                     inputsGated,
    output logic                     termOn,
    output logic [15:0]              mode0,
    output logic [15:0]              mode1,
    output logic [15:0]              mode2,
    output logic [15:0]              mode3,
    // Stored write data
    output logic [7:0]               storeData,
    output logic                     storeValid
);
    ////////////////////////////////////////////////////////////////////
    // Command decode
    wire       csLow  = !ca.csN;
    wire [2:0] strobe = {ca.rasN, ca.casN, ca.weN};
    wire       powerDownNo = !powerDown && !selfRefresh;
    wire       allowed = !inputsGated && clkEn && powerDownNo;
    dpc_pkg::dpc_cmd_e decoded;
    always_comb begin
        case (strobe)
            3'h0: decoded = dpc_pkg::DPC_MRS;
            3'h1: decoded = dpc_pkg::DPC_REF;
            3'h2: decoded = dpc_pkg::DPC_PRE;
            3'h3: decoded = dpc_pkg::DPC_ACT;
            3'h4: decoded = dpc_pkg::DPC_WR;
            3'h5: decoded = dpc_pkg::DPC_RD;
            3'h6: decoded = dpc_pkg::DPC_ZQ;
            default: decoded = dpc_pkg::DPC_NOP;
        endcase
    end
    wire take    = csLow && allowed && (decoded != dpc_pkg::DPC_NOP);
    wire isMrs   = take && (decoded == dpc_pkg::DPC_MRS);
    wire isAct   = take && (decoded == dpc_pkg::DPC_ACT);
    wire isPre   = take && (decoded == dpc_pkg::DPC_PRE);
    wire isRd    = take && (decoded == dpc_pkg::DPC_RD);
    wire isWr    = take && (decoded == dpc_pkg::DPC_WR);
    wire isRef   = take && (decoded == dpc_pkg::DPC_REF);
    wire preAll  = ca.addr[`DPC_AP_BIT];
    wire otfOn   = mode0[`DPC_OTF_BIT];
    wire chopNow = otfOn ? !ca.addr[`DPC_BC_BIT] : 1'b0;
    wire anyOpen = |bankOpen;
    wire [7:0] bankSel = 8'h01 << ca.bank;
    wire [7:0] next_bankOpen = isAct ? (bankOpen | bankSel)
                             : isPre ? (preAll ? 8'h00 : (bankOpen & ~bankSel))
                             : bankOpen;

    ////////////////////////////////////////////////////////////////////
    // Command registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cmdCode       <= 3'h0;
            cmdValid      <= 1'b0;
            cmdBank       <= 3'h0;
            rowAddr       <= 15'h0000;
            colAddr       <= 12'h000;
            autoPrecharge <= 1'b0;
            prechargeAll  <= 1'b0;
            burstChop     <= 1'b0;
            bankOpen      <= 8'h00;
        end else begin
            cmdValid <= take;
            bankOpen <= next_bankOpen;
            if (take) begin
                cmdCode <= decoded;
                cmdBank <= ca.bank;
            end
            if (isAct) begin
                rowAddr <= ca.addr;
            end
            if (isRd || isWr) begin
                colAddr       <= {ca.addr[11], ca.addr[9:0], 1'b0} >> 1;
                autoPrecharge <= ca.addr[`DPC_AP_BIT];
                burstChop     <= chopNow;
            end
            prechargeAll <= isPre && preAll;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode registers
    wire [3:0] mrsSel;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mrsel
            assign mrsSel[gi] = isMrs && (ca.bank == 3'(gi));
        end
    endgenerate
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mode0 <= `DPC_MODE_RESET;
            mode1 <= `DPC_MODE_RESET;
            mode2 <= `DPC_MODE_RESET;
            mode3 <= `DPC_MODE_RESET;
        end else begin
            if (mrsSel[0]) mode0 <= {1'b0, ca.addr};
            if (mrsSel[1]) mode1 <= {1'b0, ca.addr};
            if (mrsSel[2]) mode2 <= {1'b0, ca.addr};
            if (mrsSel[3]) mode3 <= {1'b0, ca.addr};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power states
    wire srReq    = csLow && (strobe == 3'h1) && !clkEn && !anyOpen && !powerDown && !selfRefresh;
    wire next_pd  = !selfRefresh && !clkEn && !powerDown && !srReq;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            powerDown   <= 1'b0;
            selfRefresh <= 1'b0;
            inputsGated <= 1'b0;
        end else begin
            if (selfRefresh) begin
                selfRefresh <= !clkEn;
            end else if (srReq) begin
                selfRefresh <= 1'b1;
            end
            if (powerDown) begin
                powerDown <= !clkEn;
            end else begin
                powerDown <= next_pd;
            end
            inputsGated <= powerDown || selfRefresh;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Termination
    wire rttOn    = |mode1[`DPC_RTT_LSB +: 2];
    wire tdqsOn   = BYTE_CFG && mode1[`DPC_TDQS_BIT];
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            termOn      <= 1'b0;
            termStrobe  <= 1'b0;
            termStrobeN <= 1'b1;
        end else begin
            termOn      <= rttOn && odtPin && !selfRefresh;
            termStrobe  <= tdqsOn && termOn;
            termStrobeN <= !(tdqsOn && termOn);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write path through buffer
    logic       wrWindow;
    logic [3:0] wrBeats;
    wire  [3:0] burstLen = burstChop ? 4'h4 : 4'h8;
    wire        maskOn   = !tdqsOn;
    wire        keepBeat = !(maskOn && wrBeat.mask);
    wire [7:0]  laneMask = BYTE_CFG ? 8'hff : 8'h0f;
    wire [7:0]  laneData = wrBeat.data & laneMask;
    wire        fillValid = wrWindow && wrBeatValid && keepBeat;
    wire        fillReady;
    wire        drainValid;
    wire [7:0]  drainData;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wrWindow <= 1'b0;
            wrBeats  <= 4'h0;
        end else if (cmdValid && cmdCode == 3'(dpc_pkg::DPC_WR)) begin
            wrWindow <= 1'b1;
            wrBeats  <= 4'h0;
        end else if (wrWindow && wrBeatValid) begin
            wrBeats  <= wrBeats + 4'h1;
            wrWindow <= (wrBeats + 4'h1) != burstLen;
        end
    end
    dpc_skid #(
        .WIDTH(8)
    ) u_skid (
        .clock   (clock),
        .reset_n (reset_n),
        .inValid (fillValid),
        .inReady (fillReady),
        .inData  (laneData),
        .outValid(drainValid),
        .outReady(1'b1),
        .outData (drainData)
    );
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            storeData  <= 8'h00;
            storeValid <= 1'b0;
        end else begin
            storeValid <= drainValid;
            storeData  <= drainData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read drive, strobe edge aligned
    logic [3:0] rdBeats;
    wire        rdStart = cmdValid && cmdCode == 3'(dpc_pkg::DPC_RD);
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdBeats <= 4'h0;
            dqOut   <= 8'h00;
            dqOe_n  <= 8'hff;
            dqsOut  <= 1'b0;
            dqsOe_n <= 1'b1;
        end else begin
            if (rdStart) begin
                rdBeats <= burstLen;
            end else if (rdBeats != 4'h0) begin
                rdBeats <= rdBeats - 4'h1;
            end
            dqOut   <= rdData & laneMask;
            dqOe_n  <= (rdBeats != 4'h0) ? ~laneMask : 8'hff;
            dqsOut  <= (rdBeats != 4'h0) && !dqsOut;
            dqsOe_n <= (rdBeats == 4'h0);
        end
    end

    AST_CS_MASK: assert property (@(posedge clock) disable iff (!reset_n)
        ca.csN |=> !cmdValid) else $error("command taken with chip select high");
    AST_PRE_ALL: assert property (@(posedge clock) disable iff (!reset_n)
        isPre && preAll |=> bankOpen == 8'h00) else $error("precharge all left bank open");
    AST_ACT_OPEN: assert property (@(posedge clock) disable iff (!reset_n)
        isAct |=> bankOpen[$past(ca.bank)]) else $error("activate did not open bank");
    AST_SR_EXIT: assert property (@(posedge clock) disable iff (!reset_n)
        selfRefresh && clkEn |=> !selfRefresh) else $error("self refresh exit missed");
    AST_ODT_OFF: assert property (@(posedge clock) disable iff (!reset_n)
        !rttOn |=> !termOn) else $error("termination while disabled");
    AST_GATED: assert property (@(posedge clock) disable iff (!reset_n)
        inputsGated |-> !take) else $error("command while gated");
    AST_MASKED: assert property (@(posedge clock) disable iff (!reset_n)
        fillValid |-> !(maskOn && wrBeat.mask)) else $error("masked beat stored");
    AST_DQS_OUT: assert property (@(posedge clock) disable iff (!reset_n)
        rdStart |-> ##2 !dqsOe_n) else $error("strobe not driven with read");

    ////////////////////////////////////////////////////////////////////
    // Further checks

    AST_FILL_ROOM: assert property (@(posedge clock) disable iff (!reset_n)
        fillValid |-> fillReady)
        else $error("write beat dropped");

    AST_ROW_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        isAct |=> rowAddr == $past(ca.addr))
        else $error("row address not loaded");

    AST_COL_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        isRd || isWr |=> colAddr[9:0] == $past(ca.addr[9:0]))
        else $error("column address not loaded");

    AST_AP_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        isRd || isWr |=> autoPrecharge == $past(ca.addr[`DPC_AP_BIT]))
        else $error("auto precharge flag wrong");

    AST_CHOP: assert property (@(posedge clock) disable iff (!reset_n)
        (isRd || isWr) && otfOn |=> burstChop == !$past(ca.addr[`DPC_BC_BIT]))
        else $error("burst chop wrong");

    AST_NO_OTF: assert property (@(posedge clock) disable iff (!reset_n)
        (isRd || isWr) && !otfOn |=> !burstChop)
        else $error("chop without on the fly");

    AST_CMD_BANK: assert property (@(posedge clock) disable iff (!reset_n)
        take |=> cmdBank == $past(ca.bank))
        else $error("command bank wrong");

    AST_CMD_CODE: assert property (@(posedge clock) disable iff (!reset_n)
        take |=> cmdCode == $past(decoded))
        else $error("command code wrong");

    AST_PRE_ONE: assert property (@(posedge clock) disable iff (!reset_n)
        isPre && !preAll |=> !bankOpen[$past(ca.bank)])
        else $error("precharge left bank open");

    AST_CS_BANK: assert property (@(posedge clock) disable iff (!reset_n)
        ca.csN |=> $stable(bankOpen))
        else $error("bank state changed while deselected");

    AST_MODE0_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        mrsSel[0] |=> mode0 == {1'b0, $past(ca.addr)})
        else $error("mode zero not loaded");

    AST_MODE1_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        mrsSel[1] |=> mode1 == {1'b0, $past(ca.addr)})
        else $error("mode one not loaded");

    AST_PD_ENTRY: assert property (@(posedge clock) disable iff (!reset_n)
        !powerDown && !selfRefresh && !clkEn && !srReq |=> powerDown)
        else $error("power down not entered");

    AST_PD_EXIT: assert property (@(posedge clock) disable iff (!reset_n)
        powerDown && clkEn |=> !powerDown)
        else $error("power down not left");

    AST_SR_ENTRY: assert property (@(posedge clock) disable iff (!reset_n)
        srReq |=> selfRefresh && !powerDown)
        else $error("self refresh not entered");

    AST_SR_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        selfRefresh && !clkEn |=> selfRefresh)
        else $error("self refresh left early");

    AST_PD_GATE: assert property (@(posedge clock) disable iff (!reset_n)
        powerDown |=> inputsGated)
        else $error("inputs not gated");

    AST_TERM_SR: assert property (@(posedge clock) disable iff (!reset_n)
        selfRefresh |=> !termOn)
        else $error("termination in self refresh");

    AST_TDQS_PAIR: assert property (@(posedge clock) disable iff (!reset_n)
        termStrobe != termStrobeN)
        else $error("termination strobe pair equal");

    AST_NIBBLE_HI: assert property (@(posedge clock) disable iff (!reset_n)
        !BYTE_CFG |-> dqOe_n[7:4] == 4'hf)
        else $error("upper lanes driven in nibble mode");

    AST_DQS_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
        dqsOe_n |-> dqOe_n == 8'hff)
        else $error("data driven without strobe");

    AST_WIN_OPEN: assert property (@(posedge clock) disable iff (!reset_n)
        cmdValid && cmdCode == 3'(dpc_pkg::DPC_WR) |=> wrWindow)
        else $error("write window not opened");

    AST_RD_LEN: assert property (@(posedge clock) disable iff (!reset_n)
        rdStart |=> rdBeats == $past(burstLen))
        else $error("read length wrong");
endmodule
`default_nettype wire

/* tb/dpc_ctrl_model.sv */
`default_nettype none
module dpc_ctrl_model (
    // Clock
    input  wire logic               clock,
    // Command side
    output var  dpc_pkg::dpc_ca_s   ca,
    output var  logic               clkEn,
    output var  logic               odtPin,
    // Data side
    output var  dpc_pkg::dpc_beat_s wrBeat,
    output var  logic               wrBeatValid,
    output var  logic [7:0]         rdData
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ca = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};
        clkEn = 1'b1;
        odtPin = 1'b0;
        wrBeat = '{8'h00, 1'b0};
        wrBeatValid = 1'b0;
        rdData = 8'h00;
    end

    // Read source changes every cycle so a stale word never matches
    always @(posedge clock) begin
        rdData <= rdData + 8'h01;
    end

    // One command for one cycle, then deselect with inverted address
    task automatic send(input logic cs, input logic [2:0] st, input logic [2:0] ba, input logic [14:0] a);
        @(posedge clock);
        #1;
        ca = '{cs, st[2], st[1], st[0], ba, a};
        @(posedge clock);
        #1;
        ca = '{1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a};
    endtask

    // Beat i masked when i is odd
    task automatic beats(input logic [7:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            wrBeatValid = 1'b1;
            wrBeat = '{base + 8'(i), i[0]};
        end
        @(posedge clock);
        #1;
        wrBeatValid = 1'b0;
        wrBeat = '{~wrBeat.data, 1'b0};
    endtask
endmodule
`default_nettype wire

/* tb/tb_dpc_pin_interface.sv */
`default_nettype none
module tb_dpc_pin_interface;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0]  st;
        logic [2:0]  ba;
        logic [14:0] a;
        logic [7:0]  open;
    } dpc_row_s;
    logic               clock, reset_n, clkEn, odtPin, wrBeatValid, dqsOe_n, termStrobeN, termStrobe, dqsOut;
    logic               cmdValid, autoPrecharge, prechargeAll, burstChop, powerDown, selfRefresh;
    logic               inputsGated, termOn, storeValid;
    dpc_pkg::dpc_ca_s   ca;
    dpc_pkg::dpc_beat_s wrBeat;
    logic [7:0]         rdData, dqOe_n, bankOpen, storeData, dqOut;
    logic [2:0]         cmdCode, cmdBank;
    logic [14:0]        rowAddr;
    logic [11:0]        colAddr;
    logic [15:0]        mode0, mode1, mode2, mode3;
    logic [63:0]        modeAll;
    logic [7:0]         stored [$];
    int                 fails, samples_checked, cycles;
    dpc_row_s           r;
    dpc_row_s rows [15] = '{
        '{3'h0, 3'h0, 15'h0002, 8'h00}, '{3'h0, 3'h1, 15'h0004, 8'h00}, '{3'h0, 3'h2, 15'h5a5a, 8'h00},
        '{3'h0, 3'h3, 15'h2c3d, 8'h00}, '{3'h1, 3'h0, 15'h0000, 8'h00}, '{3'h6, 3'h0, 15'h0400, 8'h00},
        '{3'h3, 3'h5, 15'h7abc, 8'h20}, '{3'h3, 3'h2, 15'h0123, 8'h24}, '{3'h5, 3'h5, 15'h1155, 8'h24},
        '{3'h4, 3'h2, 15'h02aa, 8'h24}, '{3'h2, 3'h5, 15'h0000, 8'h04}, '{3'h3, 3'h7, 15'h0001, 8'h84},
        '{3'h2, 3'h0, 15'h0400, 8'h00}, '{3'h3, 3'h3, 15'h0042, 8'h08}, '{3'h4, 3'h3, 15'h0433, 8'h08}};

    assign modeAll = {mode3, mode2, mode1, mode0};

    dpc_ctrl_model ctl (.clock, .ca, .clkEn, .odtPin, .wrBeat, .wrBeatValid, .rdData);

    dpc_pin_interface #(.DQ_WIDTH(8), .BYTE_CFG(1'b1)) uut (
        .clock, .reset_n, .ca, .clkEn, .odtPin, .wrBeat, .wrBeatValid, .rdData, .dqOut, .dqOe_n,
        .dqsOut, .dqsOe_n, .termStrobe, .termStrobeN, .cmdCode, .cmdValid, .cmdBank, .rowAddr,
        .colAddr, .autoPrecharge, .prechargeAll, .burstChop, .bankOpen, .powerDown, .selfRefresh,
        .inputsGated, .termOn, .mode0, .mode1, .mode2, .mode3, .storeData, .storeValid);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return cmdValid;
            1: return powerDown;
            2: return termOn;
            3: return ~dqsOe_n;
            default: return selfRefresh;
        endcase
    endfunction

    task automatic waitFor(input int w, input logic lvl, input int lim);
        for (int k = 0; k < lim && pick(w) !== lvl; k++) begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic quiet(input int w, input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            if (pick(w) !== 1'b0) hit = 1'b1;
            @(posedge clock);
            #1;
        end
        chkFlag(hit, 1'b0);
    endtask

    task automatic drive(input logic cke, input logic odt);
        @(posedge clock);
        #1;
        ctl.clkEn = cke;
        ctl.odtPin = odt;
    endtask

    task automatic doReset();
        reset_n = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        reset_n = 1'b1;
        chkVal(16'(dqOe_n), 16'h00ff);
        chkFlag(dqsOe_n, 1'b1);
        chkFlag(termStrobeN, 1'b1);
        chkVal(16'(bankOpen), 16'h0000);
        chkVal(mode1, 16'h0000);
    endtask

    // Send eight beats, keep what the store side reports
    task automatic wrTest(input logic tdqs);
        int n;
        stored = {};
        ctl.send(1'b0, 3'h4, 3'h4, 15'h1000);
        fork
            ctl.beats(8'h10, 8);
            repeat (30) begin
                @(posedge clock);
                #1;
                if (storeValid === 1'b1) stored.push_back(storeData);
            end
        join
        n = tdqs ? 8 : 4;
        chkVal(16'(stored.size()), 16'(n));
        foreach (stored[k]) chkVal(16'(stored[k]), 16'(8'h10 + 8'(tdqs ? k : 2 * k)));
    endtask

    task automatic test_done();
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        #1;
        doReset();
        foreach (rows[i]) begin
            r = rows[i];
            ctl.send(1'b0, r.st, r.ba, r.a);
            waitFor(0, 1'b1, 4);
            chkFlag(cmdValid, 1'b1);
            chkVal(16'(cmdCode), 16'(dpc_pkg::dpc_cmd_e'(r.st + 3'h1)));
            if (r.st inside {3'h2, 3'h3, 3'h4, 3'h5}) chkVal(16'(cmdBank), 16'(r.ba));
            if (r.st == 3'h3) chkVal(16'(rowAddr), 16'(r.a));
            if (r.st == 3'h2) chkFlag(prechargeAll, r.a[10]);
            if (r.st inside {3'h4, 3'h5}) begin
                chkVal(16'(colAddr[9:0]), 16'(r.a[9:0]));
                chkFlag(autoPrecharge, r.a[10]);
                chkFlag(burstChop, ~r.a[12]);
            end
            @(posedge clock);
            #1;
            if (r.st == 3'h0) chkVal(modeAll[r.ba[1:0] * 16 +: 16], 16'(r.a));
            if (r.st inside {3'h2, 3'h3}) chkVal(16'(bankOpen), 16'(r.open));
        end
        ctl.send(1'b1, 3'h3, 3'h6, 15'h0100);
        quiet(0, 4);
        chkVal(16'(bankOpen), 16'h0008);
        drive(1'b1, 1'b1);
        waitFor(2, 1'b1, 6);
        chkFlag(termOn, 1'b1);
        drive(1'b1, 1'b0);
        waitFor(2, 1'b0, 6);
        chkFlag(termOn, 1'b0);
        ctl.send(1'b0, 3'h0, 3'h1, 15'h0000);
        drive(1'b1, 1'b1);
        quiet(2, 6);
        drive(1'b1, 1'b0);
        ctl.send(1'b0, 3'h3, 3'h4, 15'h0010);
        wrTest(1'b0);
        ctl.send(1'b0, 3'h0, 3'h1, 15'h0804);
        wrTest(1'b1);
        drive(1'b1, 1'b1);
        waitFor(2, 1'b1, 6);
        @(posedge clock);
        #1;
        chkFlag(termStrobe, 1'b1);
        chkFlag(termStrobeN, 1'b0);
        drive(1'b1, 1'b0);
        ctl.send(1'b0, 3'h5, 3'h4, 15'h1000);
        waitFor(3, 1'b1, 16);
        chkFlag(dqsOe_n, 1'b0);
        chkVal(16'(dqOe_n), 16'h0000);
        chkFlag(dqsOut, 1'b1);
        chkVal(16'(dqOut), 16'(rdData - 8'h01));
        @(posedge clock);
        #1;
        chkFlag(dqsOut, 1'b0);
        waitFor(3, 1'b0, 16);
        chkVal(16'(dqOe_n), 16'h00ff);
        drive(1'b0, 1'b0);
        waitFor(1, 1'b1, 4);
        chkFlag(powerDown, 1'b1);
        chkFlag(selfRefresh, 1'b0);
        @(posedge clock);
        #1;
        chkFlag(inputsGated, 1'b1);
        ctl.send(1'b0, 3'h3, 3'h0, 15'h0005);
        quiet(0, 4);
        chkVal(16'(bankOpen), 16'h0018);
        drive(1'b1, 1'b0);
        waitFor(1, 1'b0, 4);
        chkFlag(powerDown, 1'b0);
        ctl.send(1'b0, 3'h2, 3'h0, 15'h0400);
        @(posedge clock);
        #1;
        ctl.clkEn = 1'b0;
        ctl.ca = '{1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 15'h0000};
        @(posedge clock);
        #1;
        ctl.ca = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};
        chkFlag(selfRefresh, 1'b1);
        chkFlag(powerDown, 1'b0);
        @(posedge clock);
        #1;
        chkFlag(inputsGated, 1'b1);
        drive(1'b1, 1'b0);
        waitFor(4, 1'b0, 4);
        chkFlag(selfRefresh, 1'b0);
        @(posedge clock);
        #1;
        doReset();
        test_done();
    end
endmodule
`default_nettype wire
